// file: logic/sfh_defines.vh
// register map, field positions and constants of the flash header sequencer
`ifndef SFH_DEFINES_VH
`define SFH_DEFINES_VH

// register offsets
`define SFH_OFS_ADDR 8'h14
`define SFH_OFS_MODE 8'h18
`define SFH_OFS_HDR 8'h1C
`define SFH_OFS_LEN 8'h20
`define SFH_OFS_STAT 8'h28

// reset values
`define SFH_RST_WORD 32'h00000000
`define SFH_RST_HALF 16'h0000
`define SFH_RST_CNT2 2'h0
`define SFH_RST_CNT3 3'h0
`define SFH_RST_LEN 20'h00000

// header count fields
`define SFH_OP_LSB 0
`define SFH_OP_MSB 1
`define SFH_AD_LSB 4
`define SFH_AD_MSB 6
`define SFH_RM_LSB 8
`define SFH_RM_MSB 9
`define SFH_DM_LSB 12
`define SFH_DM_MSB 13

// read length and mode word fields
`define SFH_LEN_MSB 19
`define SFH_MODE_MSB 15

// status fields
`define SFH_ST_BUSY 31
`define SFH_ST_CNT_MSB 19

// serial byte framing
`define SFH_BITS_BYTE 4'h8
`define SFH_BIT_LAST 4'h1
`define SFH_BIT_NONE 4'h0

`endif

// file: logic/sfh_sequencer.v
// header and read-data sequencer of a serial flash interface
`timescale 1ns/1ps
`include "sfh_defines.vh"

module sfh_sequencer
(
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // transfer control from the surrounding controller
    input wire [15:0] opcode_word,
    input wire transfer_go,
    input wire transfer_halt,
    input wire write_dir,
    output reg busy,
    // read data stream
    output reg [7:0] rd_data,
    output reg rd_valid,
    input wire rd_ready,
    // serial link
    input wire link_clk,
    output reg flash_cs_n,
    output reg flash_sclk,
    output reg sio_out,
    output reg sio_oe,
    input wire sio_in
);

localparam PH_IDLE = 3'h0;
localparam PH_OP = 3'h1;
localparam PH_ADDR = 3'h2;
localparam PH_MODE = 3'h3;
localparam PH_DUMMY = 3'h4;
localparam PH_READ = 3'h5;
localparam PH_DONE = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] flash_address_word;
reg [15:0] read_mode_word;
reg [1:0] op_byte_count;
reg [2:0] addr_byte_count;
reg [1:0] mode_byte_count;
reg [1:0] dummy_byte_count;
reg [19:0] read_length_count;
reg [19:0] captured;

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        flash_address_word <= `SFH_RST_WORD;
        read_mode_word <= `SFH_RST_HALF;
        op_byte_count <= `SFH_RST_CNT2;
        addr_byte_count <= `SFH_RST_CNT3;
        mode_byte_count <= `SFH_RST_CNT2;
        dummy_byte_count <= `SFH_RST_CNT2;
        read_length_count <= `SFH_RST_LEN;
    end
    else if (reg_wr)
    begin
        // reserved bits are not stored and read back as zero
        case (reg_addr)
            `SFH_OFS_ADDR: flash_address_word <= reg_wdata;
            `SFH_OFS_MODE: read_mode_word <= reg_wdata[`SFH_MODE_MSB:0];
            `SFH_OFS_HDR:
            begin
                op_byte_count <= reg_wdata[`SFH_OP_MSB:`SFH_OP_LSB];
                addr_byte_count <= reg_wdata[`SFH_AD_MSB:`SFH_AD_LSB];
                mode_byte_count <= reg_wdata[`SFH_RM_MSB:`SFH_RM_LSB];
                dummy_byte_count <= reg_wdata[`SFH_DM_MSB:`SFH_DM_LSB];
            end
            `SFH_OFS_LEN: read_length_count <= reg_wdata[`SFH_LEN_MSB:0];
            default: ;
        endcase
    end
end

always @(posedge core_clk)
begin
    if (sys_rst)
        reg_rdata <= `SFH_RST_WORD;
    else if (reg_rd)
    begin
        reg_rdata <= `SFH_RST_WORD;
        case (reg_addr)
            `SFH_OFS_ADDR: reg_rdata <= flash_address_word;
            `SFH_OFS_MODE: reg_rdata[`SFH_MODE_MSB:0] <= read_mode_word;
            `SFH_OFS_HDR:
            begin
                reg_rdata[`SFH_OP_MSB:`SFH_OP_LSB] <= op_byte_count;
                reg_rdata[`SFH_AD_MSB:`SFH_AD_LSB] <= addr_byte_count;
                reg_rdata[`SFH_RM_MSB:`SFH_RM_LSB] <= mode_byte_count;
                reg_rdata[`SFH_DM_MSB:`SFH_DM_LSB] <= dummy_byte_count;
            end
            `SFH_OFS_LEN: reg_rdata[`SFH_LEN_MSB:0] <= read_length_count;
            `SFH_OFS_STAT:
            begin
                reg_rdata[`SFH_ST_BUSY] <= busy;
                reg_rdata[`SFH_ST_CNT_MSB:0] <= captured;
            end
            default: ;
        endcase
    end
    else
        reg_rdata <= `SFH_RST_WORD;
end

////////////////////////////////////////////////////////////////////////////////
// synchronisers for link clock and serial input

reg lk1, lk2, lk3, lk_lvl;
reg si1, si2, si3, si_lvl;
wire lk_agree = (lk2 == lk3);
wire lk_rise = lk_agree && lk3 && !lk_lvl;
wire lk_fall = lk_agree && !lk3 && lk_lvl;
// settled input level this cycle; the registered level would lag the sampling edge by one cycle
wire si_now = (si2 == si3) ? si3 : si_lvl;

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        lk1 <= 1'b0;
        lk2 <= 1'b0;
        lk3 <= 1'b0;
        lk_lvl <= 1'b0;
        si1 <= 1'b0;
        si2 <= 1'b0;
        si3 <= 1'b0;
        si_lvl <= 1'b0;
    end
    else
    begin
        lk1 <= link_clk;
        lk2 <= lk1;
        lk3 <= lk2;
        if (lk_agree)
            lk_lvl <= lk3;
        si1 <= sio_in;
        si2 <= si1;
        si3 <= si2;
        if (si2 == si3)
            si_lvl <= si3;
    end
end

////////////////////////////////////////////////////////////////////////////////
// phase selection

reg [2:0] phase;
reg [19:0] bytes_left;
reg [3:0] bits_left;
reg [6:0] out_sh;
reg [6:0] in_sh;
reg unlimited;
reg halt_pend;
reg push_req;
reg [7:0] push_data;
reg buf_full;

// first phase at or after 'from' that has bytes to move; empty phases skip
function [2:0] pick;
    input [2:0] from;
    begin
        if (from <= PH_OP && op_byte_count != `SFH_RST_CNT2)
            pick = PH_OP;
        else if (from <= PH_ADDR && addr_byte_count != `SFH_RST_CNT3)
            pick = PH_ADDR;
        else if (from <= PH_MODE && mode_byte_count != `SFH_RST_CNT2)
            pick = PH_MODE;
        else if (from <= PH_DUMMY && dummy_byte_count != `SFH_RST_CNT2)
            pick = PH_DUMMY;
        else if (from <= PH_READ && !write_dir)
            pick = PH_READ;
        else
            pick = PH_DONE;
    end
endfunction

function [19:0] plen;
    input [2:0] ph;
    begin
        case (ph)
            PH_OP: plen = {18'h00000, op_byte_count};
            PH_ADDR: plen = {17'h00000, addr_byte_count};
            PH_MODE: plen = {18'h00000, mode_byte_count};
            PH_DUMMY: plen = {18'h00000, dummy_byte_count};
            PH_READ: plen = read_length_count;
            default: plen = `SFH_RST_LEN;
        endcase
    end
endfunction

// byte to send: the remaining count picks the byte modulo 4, highest selected first for counts up to 4
reg [31:0] sel_word;
wire [2:0] byte_idx = bytes_left[2:0] - 3'h1;
wire [31:0] sel_shift = sel_word >> {byte_idx[1:0], 3'h0};
wire [7:0] cur_byte = sel_shift[7:0];

always @*
begin
    case (phase)
        PH_OP: sel_word = {16'h0000, opcode_word};
        PH_ADDR: sel_word = flash_address_word;
        PH_MODE: sel_word = {16'h0000, read_mode_word};
        default: sel_word = `SFH_RST_WORD; // dummy bytes are zero
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// serial sequencer: data changes on link falling edge, sampled on rising

wire [2:0] after_ph = pick(phase + 3'h1);

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        phase <= PH_IDLE;
        bytes_left <= `SFH_RST_LEN;
        bits_left <= `SFH_BIT_NONE;
        out_sh <= 7'h00;
        in_sh <= 7'h00;
        unlimited <= 1'b0;
        halt_pend <= 1'b0;
        push_req <= 1'b0;
        push_data <= 8'h00;
        captured <= `SFH_RST_LEN;
        busy <= 1'b0;
        flash_cs_n <= 1'b1;
        flash_sclk <= 1'b0;
        sio_out <= 1'b0;
        sio_oe <= 1'b0;
    end
    else
    begin
        push_req <= 1'b0;
        if (phase == PH_IDLE)
        begin
            halt_pend <= 1'b0;
            if (transfer_go)
            begin
                phase <= pick(PH_OP);
                bytes_left <= plen(pick(PH_OP));
                unlimited <= (pick(PH_OP) == PH_READ) && (read_length_count == `SFH_RST_LEN);
                bits_left <= `SFH_BIT_NONE;
                captured <= `SFH_RST_LEN;
                busy <= 1'b1;
                flash_cs_n <= 1'b0;
                sio_oe <= (pick(PH_OP) != PH_READ);
            end
        end
        else
        begin
            if (transfer_halt)
                halt_pend <= 1'b1;
            if (lk_fall)
            begin
                if (phase == PH_DONE || halt_pend)
                begin
                    // end of frame: clock stays low, select released
                    phase <= PH_IDLE;
                    busy <= 1'b0;
                    flash_cs_n <= 1'b1;
                    flash_sclk <= 1'b0;
                    sio_oe <= 1'b0;
                    sio_out <= 1'b0;
                end
                else if (phase == PH_READ)
                begin
                    // a new byte waits while the buffer cannot take it
                    if (bits_left != `SFH_BIT_NONE || !buf_full)
                    begin
                        // line released on a falling clock, never beside a rising one
                        sio_oe <= 1'b0;
                        flash_sclk <= 1'b0;
                        if (bits_left == `SFH_BIT_NONE)
                            bits_left <= `SFH_BITS_BYTE;
                    end
                end
                else
                begin
                    flash_sclk <= 1'b0;
                    if (bits_left == `SFH_BIT_NONE)
                    begin
                        bits_left <= `SFH_BITS_BYTE;
                        sio_out <= cur_byte[7];
                        out_sh <= cur_byte[6:0];
                    end
                    else
                    begin
                        sio_out <= out_sh[6];
                        out_sh <= {out_sh[5:0], 1'b0};
                    end
                end
            end
            else if (lk_rise && bits_left != `SFH_BIT_NONE && !flash_sclk)
            begin
                flash_sclk <= 1'b1;
                if (bits_left == `SFH_BIT_LAST)
                begin
                    bits_left <= `SFH_BIT_NONE;
                    if (phase == PH_READ)
                    begin
                        push_req <= 1'b1;
                        push_data <= {in_sh, si_now};
                        captured <= captured + 20'h00001;
                        if (!unlimited)
                            bytes_left <= bytes_left - 20'h00001;
                        if (!unlimited && bytes_left == 20'h00001)
                            phase <= PH_DONE;
                    end
                    else if (bytes_left == 20'h00001)
                    begin
                        phase <= after_ph;
                        bytes_left <= plen(after_ph);
                        unlimited <= (after_ph == PH_READ) && (read_length_count == `SFH_RST_LEN);
                    end
                    else
                        bytes_left <= bytes_left - 20'h00001;
                end
                else
                begin
                    bits_left <= bits_left - 4'h1;
                    in_sh <= {in_sh[5:0], si_now};
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// two-entry read buffer; rd_data is the head entry

reg [7:0] buf_tail;
wire pop = rd_valid && rd_ready;

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        rd_data <= 8'h00;
        rd_valid <= 1'b0;
        buf_tail <= 8'h00;
        buf_full <= 1'b0;
    end
    else if (pop && push_req)
    begin
        if (buf_full)
        begin
            rd_data <= buf_tail;
            buf_tail <= push_data;
        end
        else
            rd_data <= push_data;
    end
    else if (pop)
    begin
        rd_data <= buf_tail;
        rd_valid <= buf_full;
        buf_full <= 1'b0;
    end
    else if (push_req)
    begin
        if (!rd_valid)
        begin
            rd_data <= push_data;
            rd_valid <= 1'b1;
        end
        else if (!buf_full)
        begin
            buf_tail <= push_data;
            buf_full <= 1'b1;
        end
    end
end

endmodule // sfh_sequencer

// file: verif/sfh_chk.sv
// port assertions of the flash header sequencer
`timescale 1ns/1ps
module sfh_chk
(
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // register port
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // control and read stream
    input wire transfer_go,
    input wire transfer_halt,
    input wire busy,
    input wire [7:0] rd_data,
    input wire rd_valid,
    input wire rd_ready,
    // serial link
    input wire flash_cs_n,
    input wire flash_sclk,
    input wire sio_out,
    input wire sio_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    rdata_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data not zero outside answer cycle");
    go_opens_frame_a: assert property (transfer_go && !busy |=> busy && !flash_cs_n)
        else $error("start did not open a frame");
    idle_pins_quiet_a: assert property (!busy |-> flash_cs_n && !flash_sclk && !sio_oe)
        else $error("serial pins active while idle");
    sclk_high_hold_a: assert property ($rose(flash_sclk) |-> flash_sclk [*3])
        else $error("serial clock high too short");
    sclk_low_hold_a: assert property ($fell(flash_sclk) && !flash_cs_n |-> !flash_sclk [*3])
        else $error("serial clock low too short");
    data_steady_high_a: assert property (flash_sclk && $past(flash_sclk) |-> $stable(sio_out))
        else $error("data changed while clock high");
    full_hold_byte_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("unread byte lost");
    halt_closes_frame_a: assert property (transfer_halt && busy |-> ##[1:20] !busy)
        else $error("halt did not end the frame");
    cover property (transfer_go && !busy);
    cover property (rd_valid && !rd_ready && busy);
    cover property (transfer_halt && busy);
endmodule // sfh_chk

bind sfh_sequencer sfh_chk chk (.core_clk, .sys_rst, .reg_rd, .reg_rdata, .transfer_go, .transfer_halt,
    .busy, .rd_data, .rd_valid, .rd_ready, .flash_cs_n, .flash_sclk, .sio_out, .sio_oe);

// file: verif/sfh_flash_model.sv
// behavioural serial flash on the far side of the sequencer
`timescale 1ns/1ps
module sfh_flash_model
(
    // clock for the idle pattern
    input wire core_clk,
    // serial link
    input wire flash_cs_n,
    input wire flash_sclk,
    input wire sio_out,
    input wire sio_oe,
    output reg line
);
    bit hdr_q[$];
    int idx = 0;
    reg drv = 1'b0;
    reg bitv = 1'b0;
    reg tog = 1'b0;
    reg [7:0] cur;
    function automatic [7:0] pat(input int n);
        pat = 8'h5A ^ 8'(n * 29);
    endfunction
    // header bits are taken on the rising clock, read bits counted there
    always @(posedge flash_sclk)
        if (!flash_cs_n)
        begin
            if (sio_oe)
                hdr_q.push_back(sio_out);
            else
                idx++;
        end
    // read data change after the falling clock, mode 0
    always @(negedge flash_sclk or negedge sio_oe or posedge flash_cs_n)
    begin
        #1;
        drv = !flash_cs_n && !sio_oe;
        if (flash_cs_n)
            idx = 0;
        cur = pat(idx >> 3);
        bitv = cur[7 - (idx & 7)];
    end
    always @(posedge core_clk)
        tog <= ~tog;
    // released line shows a changing pattern, never the last bit
    always @*
        line = sio_oe ? sio_out : (drv ? bitv : tog);
endmodule // sfh_flash_model

// file: verif/serial_flash_header_sequencer_test.sv
// self-checking bench of the flash header sequencer
`timescale 1ns/1ps
`include "sfh_defines.vh"
module serial_flash_header_sequencer_test;
    reg core_clk, sys_rst, reg_wr, reg_rd, transfer_go, transfer_halt, write_dir, rd_ready, link_clk, stall;
    reg [7:0] reg_addr;
    reg [31:0] reg_wdata, rv;
    reg [15:0] opcode_word;
    wire [31:0] reg_rdata;
    wire [7:0] rd_data;
    wire busy, rd_valid, flash_cs_n, flash_sclk, sio_out, sio_oe, sio_in;
    int n_fail = 0;
    int cmp_count = 0;
    logic [7:0] rx_q[$];
    bit exp_q[$];
    reg [7:0] ofs[6] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h24};
    reg [31:0] ones[6] = '{32'hFFFFFFFF, 32'h0000FFFF, 32'h00003373, 32'h000FFFFF, 32'h00000000, 32'h00000000};
    sfh_sequencer DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .opcode_word,
        .transfer_go, .transfer_halt, .write_dir, .busy, .rd_data, .rd_valid, .rd_ready, .link_clk,
        .flash_cs_n, .flash_sclk, .sio_out, .sio_oe, .sio_in);
    sfh_flash_model FLASH (.core_clk, .flash_cs_n, .flash_sclk, .sio_out, .sio_oe, .line(sio_in));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        link_clk = 0;
        #7;
        forever #160 link_clk = ~link_clk;
    end
    // consumer with random and forced stalls
    always @(posedge core_clk)
    begin
        rd_ready <= !stall && ($urandom % 4 != 0);
        if (rd_valid && rd_ready)
            rx_q.push_back(rd_data);
    end
    ////////////////////////////////////////////////////////////////////////
    task give_verdict;
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input [7:0] a, output [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task push_byte(input [7:0] v);
        for (int i = 7; i >= 0; i--)
            exp_q.push_back(v[i]);
    endtask
    task xfer(input [1:0] op, input [2:0] ad, input [1:0] rm, input [1:0] dm, input [19:0] len, input wd,
        input int hc, input st);
        reg [31:0] a;
        reg [31:0] m;
        reg [15:0] o;
        int i;
        a = $urandom;
        m = $urandom;
        o = $urandom;
        wr(`SFH_OFS_ADDR, a);
        wr(`SFH_OFS_MODE, {16'h0000, m[15:0]});
        wr(`SFH_OFS_HDR, {18'h00000, dm, 2'h0, rm, 1'b0, ad, 2'h0, op});
        wr(`SFH_OFS_LEN, {12'h000, len});
        @(posedge core_clk);
        opcode_word <= o;
        write_dir <= wd;
        stall <= st;
        FLASH.hdr_q.delete();
        rx_q.delete();
        exp_q.delete();
        transfer_go <= 1;
        @(posedge core_clk);
        transfer_go <= 0;
        // a second start mid-frame must not restart the header
        repeat (20) @(posedge core_clk);
        transfer_go <= 1;
        @(posedge core_clk);
        transfer_go <= 0;
        if (st)
        begin
            repeat (700) @(posedge core_clk);
            stall <= 0;
        end
        for (i = 0; hc > 0 && rx_q.size() < hc && i < 50000; i++)
            @(posedge core_clk);
        if (hc > 0)
        begin
            transfer_halt <= 1;
            @(posedge core_clk);
            transfer_halt <= 0;
        end
        for (i = 0; busy !== 1'b0 && i < 50000; i++)
            @(posedge core_clk);
        repeat (40) @(posedge core_clk);
        for (i = op; i > 0; i--)
            push_byte(8'(o >> (8 * i - 8)));
        for (i = ad; i > 0; i--)
            push_byte(8'(a >> (8 * i - 8)));
        for (i = rm; i > 0; i--)
            push_byte(8'(m >> (8 * i - 8)));
        for (i = 0; i < dm; i++)
            push_byte(8'h00);
        chk(FLASH.hdr_q.size(), exp_q.size());
        foreach (exp_q[j])
            chk(FLASH.hdr_q[j], exp_q[j]);
        if (wd || len > 0)
            chk(rx_q.size(), wd ? 0 : len);
        else
            chk(rx_q.size() >= hc, 1);
        foreach (rx_q[j])
            chk(rx_q[j], FLASH.pat(j));
        if (!wd && len > 0)
        begin
            rd(`SFH_OFS_STAT, rv);
            chk(rv, {12'h000, len});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_wr, reg_rd, transfer_go, transfer_halt, write_dir, stall} = 0;
        reg_addr = 0;
        reg_wdata = 0;
        opcode_word = 0;
        sys_rst = 1;
        void'($urandom(47));
        repeat (16) @(posedge core_clk);
        sys_rst <= 0;
        for (int k = 0; k < 6; k++)
        begin
            rd(ofs[k], rv);
            chk(rv, 32'h00000000);
        end
        for (int k = 0; k < 6; k++)
        begin
            wr(ofs[k], 32'hFFFFFFFF);
            rd(ofs[k], rv);
            chk(rv, ones[k]);
        end
        xfer(1, 0, 0, 0, 0, 1, 0, 0);
        xfer(2, 4, 2, 3, 3, 0, 0, 0);
        xfer(0, 1, 1, 1, 5, 0, 0, 1);
        xfer(1, 2, 0, 2, 2, 0, 0, 0);
        xfer(2, 3, 1, 0, 0, 0, 3, 0);
        give_verdict;
    end
    initial
    begin
        #2000000;
        n_fail++;
        give_verdict;
    end
endmodule // serial_flash_header_sequencer_test
